// file: verilog/wcam_monitor.sv
// Weld cycle alarm monitor with Wishbone register access
`timescale 1ns/10ps
`include "wcam_defs.svh"
module wcam_monitor #(
    parameter int TIMEOUT_CYC = `WCAM_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Cycle inputs
    input wire logic cycle_start_i,
    input wire logic upper_limit_switch_i,
    input wire logic trigger_i,
    input wire logic ext_delay_i,
    input wire logic interlock_i,
    input wire logic part_present_i,
    input wire logic rf_feedback_i,
    input wire logic [7:0] horn_number_i,
    // Fault conditions
    input wire logic serial_fail_i,
    input wire logic display_comm_fail_i,
    input wire logic fieldbus_present_i,
    input wire logic fieldbus_ok_i,
    input wire logic display_nvram_fail_i,
    input wire logic main_nvram_fail_i,
    input wire logic sdram_fail_i,
    input wire logic display_link_fail_i,
    input wire logic dcb_link_fail_i,
    input wire logic line_lost_i,
    input wire logic aux_24v_ok_i,
    // Results
    output logic cycle_active_o,
    output logic cycle_abort_o,
    output logic start_blocked_o,
    output logic [7:0] drive_status_word_o,
    output logic powerup_go_o,
    output wcam_pkg::wcam_pu_t powerup_action_o
);
    import wcam_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        wcam_phase_t phase;   // Cycle phase
        logic [31:0] cnt;     // Time-out counter
        logic [31:0] rf_cnt;  // Switch feedback counter
        logic rf_wait;        // Waiting on feedback
        logic [7:0] nocyc;    // No-cycle group
        logic fb_seen;        // Fieldbus present at power-on
        logic por_done;       // Power-on sampling done
        logic [31:0] ctrl;    // Control register
        logic [31:0] tmo;     // System time-out
        logic [31:0] rftime;  // Feedback time
        logic line_was;       // Line loss flag last cycle
        logic abort;          // Abort pulse
        logic pu_go;          // Power-up pulse
        logic [31:0] rdata;   // Read data
        logic ack;            // Bus ack
    } wcam_state_t;

    wcam_state_t st_reg;
    wcam_state_t st_next;

    // Fault-gated groups
    logic [7:0] comm_fault;
    logic [7:0] hw_fault;
    logic [7:0] comm_flags;
    logic [7:0] hw_flags;
    logic [7:0] clr_comm;
    logic [7:0] clr_hw;
    logic bus_wr;
    logic start_ok;
    logic any_abort;

    ////////////////////////////////////////////////////////////////////////////
    // Fault levels
    always_comb begin
        comm_fault = 8'h00;
        hw_fault = 8'h00;
        comm_fault[`WCAM_BIT1] = serial_fail_i;
        comm_fault[`WCAM_BIT2] = display_comm_fail_i;
        comm_fault[`WCAM_BIT3] = st_reg.fb_seen && !fieldbus_ok_i;
        hw_fault[`WCAM_BIT1] = display_nvram_fail_i;
        hw_fault[`WCAM_BIT2] = main_nvram_fail_i;
        hw_fault[`WCAM_BIT3] = sdram_fail_i;
        hw_fault[`WCAM_BIT4] = display_link_fail_i;
        hw_fault[`WCAM_BIT5] = dcb_link_fail_i;
        hw_fault[`WCAM_BIT6] = line_lost_i && aux_24v_ok_i;
    end

    assign bus_wr = cyc_i && stb_i && we_i && !st_reg.ack;
    assign clr_comm = (bus_wr && adr_i == `WCAM_OFF_CLEAR && sel_i[1]) ? dat_i[15:8] : 8'h00;
    assign clr_hw = (bus_wr && adr_i == `WCAM_OFF_CLEAR && sel_i[2]) ? dat_i[23:16] : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Latched communication and hardware bits
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bits
            wcam_alarm_bit u_comm (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .set_i(comm_fault[g]),
                .fault_i(comm_fault[g]),
                .clear_i(clr_comm[g]),
                .flag_o(comm_flags[g])
            );
            wcam_alarm_bit u_hw (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .set_i(hw_fault[g]),
                .fault_i(hw_fault[g]),
                .clear_i(clr_hw[g]),
                .flag_o(hw_flags[g])
            );
        end
    endgenerate

    assign start_ok = cycle_start_i && (hw_flags == 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [7:0] nset;
        logic [7:0] nclr;
        nset = 8'h00;
        nclr = 8'h00;
        st_next = st_reg;
        st_next.abort = 1'b0;
        st_next.pu_go = 1'b0;
        st_next.ack = 1'b0;
        st_next.line_was = hw_flags[`WCAM_BIT6];
        // Power-on fieldbus sampling
        if (!st_reg.por_done) begin
            st_next.por_done = 1'b1;
            st_next.fb_seen = fieldbus_present_i;
        end
        // Cycle sequence
        unique case (st_reg.phase)
            WCAM_IDLE: begin
                if (start_ok) begin
                    st_next.phase = WCAM_ULS;
                    st_next.cnt = 32'h0000_0000;
                    if (st_reg.ctrl[`WCAM_CTRL_ILK_EN] && !interlock_i) begin
                        nset[`WCAM_BIT4] = 1'b1;
                    end
                    if (!part_present_i) begin
                        nset[`WCAM_BIT6] = 1'b1;
                    end
                    if (horn_number_i >= 8'(`WCAM_HORN_COUNT)) begin
                        nset[`WCAM_BIT7] = 1'b1;
                    end
                    st_next.rf_wait = st_reg.ctrl[`WCAM_CTRL_RF_EN];
                    st_next.rf_cnt = 32'h0000_0000;
                end
            end
            WCAM_ULS: begin
                st_next.cnt = st_reg.cnt + 32'h0000_0001;
                if (!upper_limit_switch_i) begin
                    st_next.phase = WCAM_TRIG;
                    st_next.cnt = 32'h0000_0000;
                end else if (st_reg.cnt >= st_reg.tmo) begin
                    nset[`WCAM_BIT1] = 1'b1;
                end
            end
            WCAM_TRIG: begin
                st_next.cnt = st_reg.cnt + 32'h0000_0001;
                if (trigger_i) begin
                    st_next.phase = st_reg.ctrl[`WCAM_CTRL_EXT_EN] ? WCAM_EXT : WCAM_WELD;
                    st_next.cnt = 32'h0000_0000;
                end else if (st_reg.cnt >= st_reg.tmo) begin
                    nset[`WCAM_BIT2] = 1'b1;
                end
            end
            WCAM_EXT: begin
                st_next.cnt = st_reg.cnt + 32'h0000_0001;
                if (ext_delay_i) begin
                    st_next.phase = WCAM_WELD;
                end else if (st_reg.cnt >= st_reg.tmo) begin
                    nset[`WCAM_BIT3] = 1'b1;
                end
            end
            WCAM_WELD: begin
                if (!cycle_start_i) begin
                    st_next.phase = WCAM_IDLE;
                end
            end
            default: begin
                st_next.phase = WCAM_IDLE;
            end
        endcase
        // Switch feedback timer
        if (st_reg.rf_wait) begin
            st_next.rf_cnt = st_reg.rf_cnt + 32'h0000_0001;
            if (rf_feedback_i) begin
                st_next.rf_wait = 1'b0;
            end else if (st_reg.rf_cnt >= st_reg.rftime) begin
                nset[`WCAM_BIT5] = 1'b1;
                st_next.rf_wait = 1'b0;
            end
        end
        // Abort on any group alarm
        // no-cycle abort
        // hardware abort
        // A cycle that ends naturally in this same cycle still counts as running
        if ((st_reg.phase != WCAM_IDLE || st_next.phase != WCAM_IDLE) &&
            ((nset | st_reg.nocyc) != 8'h00 || comm_flags != 8'h00 || hw_flags != 8'h00)) begin
            st_next.phase = WCAM_IDLE;
            st_next.rf_wait = 1'b0;
            st_next.abort = 1'b1;
        end
        if (st_reg.line_was && !hw_flags[`WCAM_BIT6]) begin
            st_next.pu_go = 1'b1;
        end
        // Bus access
        if (cyc_i && stb_i && !st_reg.ack) begin
            st_next.ack = 1'b1;
            st_next.rdata = 32'h0000_0000;
            if (we_i) begin
                unique case (adr_i)
                    `WCAM_OFF_CTRL: st_next.ctrl = dat_i;
                    `WCAM_OFF_TIMEOUT: st_next.tmo = dat_i;
                    `WCAM_OFF_RFTIME: st_next.rftime = dat_i;
                    `WCAM_OFF_CLEAR: nclr = sel_i[0] ? dat_i[7:0] : 8'h00;
                    default: begin
                    end
                endcase
            end else begin
                unique case (adr_i)
                    `WCAM_OFF_NOCYC: st_next.rdata = {24'h000000, st_reg.nocyc};
                    `WCAM_OFF_COMM: st_next.rdata = {24'h000000, comm_flags};
                    `WCAM_OFF_HW: st_next.rdata = {24'h000000, hw_flags};
                    `WCAM_OFF_CTRL: st_next.rdata = st_reg.ctrl;
                    `WCAM_OFF_STATUS: st_next.rdata = {29'h0, st_reg.phase};
                    `WCAM_OFF_TIMEOUT: st_next.rdata = st_reg.tmo;
                    `WCAM_OFF_RFTIME: st_next.rdata = st_reg.rftime;
                    default: st_next.rdata = 32'h0000_0000;
                endcase
            end
        end
        st_next.nocyc = ((st_reg.nocyc & ~nclr) | nset) & 8'hFE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.phase <= WCAM_IDLE;
            st_reg.ctrl <= `WCAM_CTRL_RESET;
            st_reg.tmo <= 32'(TIMEOUT_CYC);
            st_reg.rftime <= `WCAM_RFTIME_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign dat_o = st_reg.rdata;
    assign ack_o = st_reg.ack;
    assign cycle_active_o = (st_reg.phase != WCAM_IDLE);
    assign cycle_abort_o = st_reg.abort;
    assign start_blocked_o = (hw_flags != 8'h00);
    assign drive_status_word_o = {7'h00, hw_flags[`WCAM_BIT6]};
    assign powerup_go_o = st_reg.pu_go;
    assign powerup_action_o = wcam_pu_t'(st_reg.ctrl[`WCAM_CTRL_PU_LSB +: 2]);
    assign any_abort = st_reg.abort;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_hw_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.phase == WCAM_IDLE && hw_flags != 8'h00) |=> st_reg.phase == WCAM_IDLE)
        else $error("cycle started during hardware alarm");
    a_hw_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.phase != WCAM_IDLE && hw_flags != 8'h00) |=> any_abort)
        else $error("hardware alarm did not abort");
    a_comm_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.phase != WCAM_IDLE && comm_flags != 8'h00) |=> st_reg.phase == WCAM_IDLE)
        else $error("communication alarm did not abort");
    a_uls_tmo: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.phase == WCAM_ULS && upper_limit_switch_i && st_reg.cnt >= st_reg.tmo)
        |=> st_reg.nocyc[`WCAM_BIT1])
        else $error("limit switch time-out missed");
    a_trig_tmo: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.phase == WCAM_TRIG && !trigger_i && st_reg.cnt >= st_reg.tmo)
        |=> st_reg.nocyc[`WCAM_BIT2] ##1 st_reg.phase == WCAM_IDLE)
        else $error("trigger time-out missed");
    a_nocyc_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.phase != WCAM_IDLE && (st_next.nocyc & ~st_reg.nocyc) != 8'h00)
        |=> st_reg.phase == WCAM_IDLE && any_abort)
        else $error("no-cycle alarm did not abort");
    a_fb_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.por_done && !st_reg.fb_seen) |-> !comm_flags[`WCAM_BIT3])
        else $error("absent fieldbus raised alarm");
    a_hw_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_fault[`WCAM_BIT6] |=> hw_flags[`WCAM_BIT6] [*1])
        else $error("line alarm not held");
    a_estop_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        hw_flags[`WCAM_BIT6] |-> drive_status_word_o[0])
        else $error("emergency stop flag missing");
    a_pu_go: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(hw_flags[`WCAM_BIT6]) |=> powerup_go_o)
        else $error("power-up action not started");
    c_abort: cover property (@(posedge clk_i) disable iff (rst_i) any_abort);
    c_weld: cover property (@(posedge clk_i) disable iff (rst_i) st_reg.phase == WCAM_WELD);
    c_line: cover property (@(posedge clk_i) disable iff (rst_i) powerup_go_o);
endmodule // wcam_monitor

// file: verilog/wcam_defs.svh
// Offsets, field positions, reset values and timing counts of the alarm monitor
`ifndef WCAM_DEFS_SVH
`define WCAM_DEFS_SVH
// Register word offsets (byte addresses)
`define WCAM_OFF_NOCYC    8'h00
`define WCAM_OFF_COMM     8'h04
`define WCAM_OFF_HW       8'h08
`define WCAM_OFF_CTRL     8'h0C
`define WCAM_OFF_CLEAR    8'h10
`define WCAM_OFF_STATUS   8'h14
`define WCAM_OFF_TIMEOUT  8'h18
`define WCAM_OFF_RFTIME   8'h1C
// Alarm bit positions (common to every group)
`define WCAM_BIT1 1
`define WCAM_BIT2 2
`define WCAM_BIT3 3
`define WCAM_BIT4 4
`define WCAM_BIT5 5
`define WCAM_BIT6 6
`define WCAM_BIT7 7
// Control register fields
`define WCAM_CTRL_EXT_EN   0
`define WCAM_CTRL_ILK_EN   1
`define WCAM_CTRL_RF_EN    2
`define WCAM_CTRL_PU_LSB   4
`define WCAM_CTRL_RESET    32'h0000_0000
// Horn numbers accepted for switching
`define WCAM_HORN_COUNT    16
// System time-out in milliseconds and its cycle count at 100 MHz
`define WCAM_TIMEOUT_MS    1
`define WCAM_CLK_MHZ       100
`define WCAM_TIMEOUT_CYC   (`WCAM_TIMEOUT_MS * 1000 * `WCAM_CLK_MHZ)
// Default switch feedback time in cycles
`define WCAM_RFTIME_RESET  32'h0000_03E8
`endif

// file: verilog/wcam_pkg.sv
// Types of the alarm monitor
package wcam_pkg;
    // Weld cycle phases, Gray coded from IDLE through ULS, TRIG and EXT to WELD
    typedef enum logic [2:0] {
        WCAM_IDLE = 3'b000,
        WCAM_ULS  = 3'b001,
        WCAM_TRIG = 3'b011,
        WCAM_EXT  = 3'b010,
        WCAM_WELD = 3'b110
    } wcam_phase_t;
    // Power-up action after line voltage returns
    typedef enum logic [1:0] {
        WCAM_PU_NONE = 2'b00,
        WCAM_PU_SEEK = 2'b01,
        WCAM_PU_SCAN = 2'b10
    } wcam_pu_t;
endpackage

// file: verilog/wcam_alarm_bit.sv
// One latched alarm bit with fault-gated clear
`timescale 1ns/10ps
module wcam_alarm_bit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic fault_i,
    input wire logic clear_i,
    output logic flag_o
);
    // Latched flag
    logic flag_reg;
    logic flag_next;
    // Set wins; clear only once fault is gone
    always_comb begin
        flag_next = flag_reg;
        if (set_i) begin
            flag_next = 1'b1;
        end else if (clear_i && !fault_i) begin
            flag_next = 1'b0;
        end
    end
    // Register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end
    assign flag_o = flag_reg;
endmodule // wcam_alarm_bit

// file: dv/wcam_far_model.sv
// Far-side model: actuator limit switch and user feedback inputs
`timescale 1ns/10ps
module wcam_far_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cycle_active_i,
    input wire logic [7:0] uls_dly_i,
    input wire logic [7:0] trig_dly_i,
    input wire logic [7:0] ext_dly_i,
    input wire logic [7:0] rf_dly_i,
    output logic upper_limit_switch_o,
    output logic trigger_o,
    output logic ext_delay_o,
    output logic rf_feedback_o
);
    logic [7:0] cnt_reg; // Cycles since the weld cycle became active

    ////////////////////////////////////////////////////////////////////////////////
    // Count while a cycle runs; it saturates below FF so FF means never
    always_ff @(posedge clk_i) begin
        if (rst_i || !cycle_active_i) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg != 8'hFE) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // True once a programmed delay has run out
    function automatic logic due(input logic [7:0] d, input logic [7:0] c);
        return (d != 8'hFF) && (c >= d);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Limit switch rests active at the top; the others rest inactive
    assign upper_limit_switch_o = !(cycle_active_i && due(uls_dly_i, cnt_reg));
    assign trigger_o = cycle_active_i && due(trig_dly_i, cnt_reg);
    assign ext_delay_o = cycle_active_i && due(ext_dly_i, cnt_reg);
    assign rf_feedback_o = cycle_active_i && due(rf_dly_i, cnt_reg);
endmodule // wcam_far_model

// file: dv/tb_top.sv
// Self-checking bench for the weld cycle alarm monitor
`timescale 1ns/10ps
`include "wcam_defs.svh"
module tb_top;
    import wcam_pkg::*;
    localparam int TMO = 20; // Short system time-out for simulation
    // One cycle scenario: control bits, partner delays, user inputs, expected word
    typedef struct packed {
        logic [2:0] ctrl;
        logic [7:0] upper_limit_switch, trig, ext, rf;
        logic ilk, part;
        logic [7:0] horn, exp;
    } wcam_case_t;
    logic clk_i, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00, horn_number_i = 8'h00;
    logic [7:0] uls_d = 8'h02, trig_d = 8'h03, ext_d = 8'hFF, rf_d = 8'hFF;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic cycle_start_i = 1'b0, interlock_i = 1'b1, part_present_i = 1'b1;
    logic fieldbus_present_i = 1'b1, aux_24v_ok_i = 1'b1;
    logic upper_limit_switch_i, trigger_i, ext_delay_i, rf_feedback_i, ack_o;
    logic cycle_active_o, cycle_abort_o, start_blocked_o, powerup_go_o;
    logic [7:0] drive_status_word_o;
    wcam_pu_t powerup_action_o;
    logic [8:0] flt = 9'h000; // Fault levels: comm 0..2, hardware 3..8
    int n_mismatch = 0, check_count = 0, n_abort = 0;
    logic [7:0] roff [8] = '{`WCAM_OFF_NOCYC, `WCAM_OFF_COMM, `WCAM_OFF_HW, `WCAM_OFF_CTRL,
        `WCAM_OFF_STATUS, `WCAM_OFF_TIMEOUT, `WCAM_OFF_RFTIME, 8'h20};
    logic [31:0] rexp [8] = '{32'h0, 32'h0, 32'h0, `WCAM_CTRL_RESET, 32'h0, 32'(TMO),
        `WCAM_RFTIME_RESET, 32'h0};
    wcam_case_t cases [10] = '{
        '{3'h0, 8'h02, 8'h03, 8'hFF, 8'hFF, 1'b0, 1'b1, 8'h0F, 8'h00},
        '{3'h7, 8'h02, 8'h03, 8'h04, 8'h02, 1'b1, 1'b1, 8'h00, 8'h00},
        '{3'h0, 8'hFF, 8'h03, 8'hFF, 8'hFF, 1'b1, 1'b1, 8'h00, 8'h02},
        '{3'h0, 8'h02, 8'hFF, 8'hFF, 8'hFF, 1'b1, 1'b1, 8'h00, 8'h04},
        '{3'h1, 8'h02, 8'h03, 8'hFF, 8'hFF, 1'b1, 1'b1, 8'h00, 8'h08},
        '{3'h2, 8'h02, 8'h03, 8'hFF, 8'hFF, 1'b0, 1'b1, 8'h00, 8'h10},
        '{3'h4, 8'h02, 8'h03, 8'hFF, 8'hFF, 1'b1, 1'b1, 8'h00, 8'h20},
        '{3'h0, 8'h02, 8'h03, 8'hFF, 8'hFF, 1'b1, 1'b0, 8'h00, 8'h40},
        '{3'h0, 8'h02, 8'h03, 8'hFF, 8'hFF, 1'b1, 1'b1, 8'h10, 8'h80},
        '{3'h0, 8'h02, 8'h03, 8'hFF, 8'hFF, 1'b1, 1'b1, 8'hFF, 8'h80}};

    ////////////////////////////////////////////////////////////////////////////////
    // Design and far-side model
    wcam_monitor #(.TIMEOUT_CYC(TMO)) dut_u (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .cycle_start_i, .upper_limit_switch_i, .trigger_i, .ext_delay_i, .interlock_i,
        .part_present_i, .rf_feedback_i, .horn_number_i,
        .serial_fail_i(flt[0]), .display_comm_fail_i(flt[1]), .fieldbus_present_i,
        .fieldbus_ok_i(!flt[2]), .display_nvram_fail_i(flt[3]), .main_nvram_fail_i(flt[4]),
        .sdram_fail_i(flt[5]), .display_link_fail_i(flt[6]), .dcb_link_fail_i(flt[7]),
        .line_lost_i(flt[8]), .aux_24v_ok_i, .cycle_active_o, .cycle_abort_o,
        .start_blocked_o, .drive_status_word_o, .powerup_go_o, .powerup_action_o);
    wcam_far_model far_u (
        .clk_i, .rst_i, .cycle_active_i(cycle_active_o), .uls_dly_i(uls_d),
        .trig_dly_i(trig_d), .ext_dly_i(ext_d), .rf_dly_i(rf_d),
        .upper_limit_switch_o(upper_limit_switch_i), .trigger_o(trigger_i),
        .ext_delay_o(ext_delay_i), .rf_feedback_o(rf_feedback_i));

    // Free-running clock and abort pulse counter
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (cycle_abort_o === 1'b1) n_abort <= n_abort + 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, bus and wait helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%08h exp=%08h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        q = dat_o;
        chk({31'h0, ack_o}, 32'h1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb(1'b1, a, d, s, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, 4'hF, q);
        chk(q, e);
    endtask
    // Picks abort (0), active (1) or power-up go (2)
    function automatic logic pick(input int w);
        logic [2:0] v;
        v = {powerup_go_o, cycle_active_o, cycle_abort_o};
        return v[w];
    endfunction
    task automatic wait_sig(input int w, input logic lvl, input int lim);
        int i;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (pick(w) !== lvl && i < lim);
    endtask
    // Group bit expected for each fault source
    function automatic logic [31:0] exp_bit(input int k);
        return 32'h1 << ((k < 3) ? k + 1 : k - 2);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // One weld cycle against the far-side model
    task automatic run_case(input wcam_case_t c);
        int a0;
        wr(`WCAM_OFF_CTRL, {29'h0, c.ctrl}, 4'hF);
        @(posedge clk_i);
        uls_d <= c.upper_limit_switch;
        trig_d <= c.trig;
        ext_d <= c.ext;
        rf_d <= c.rf;
        interlock_i <= c.ilk;
        part_present_i <= c.part;
        horn_number_i <= (c.horn == 8'hFF) ? 8'(16 + $urandom_range(238)) : c.horn;
        a0 = n_abort;
        cycle_start_i <= 1'b1;
        wait_sig(0, 1'b1, 120);
        cycle_start_i <= 1'b0;
        wait_sig(1, 1'b0, 200);
        chk({31'h0, cycle_active_o}, 32'h0);
        chk(32'(n_abort != a0), 32'(c.exp != 8'h00));
        rd_chk(`WCAM_OFF_NOCYC, {24'h0, c.exp});
        wr(`WCAM_OFF_CLEAR, 32'h0000_00FF, 4'h1);
        rd_chk(`WCAM_OFF_NOCYC, 32'h0);
    endtask

    // A fault raised mid-cycle, cleared first too early, then properly
    task automatic fault_case(input int k, input logic [1:0] pu);
        int a0;
        logic [7:0] off;
        logic [3:0] s;
        off = (k < 3) ? `WCAM_OFF_COMM : `WCAM_OFF_HW;
        s = (k < 3) ? 4'h2 : 4'h4;
        wr(`WCAM_OFF_CTRL, {26'h0, pu, 4'h0}, 4'hF);
        a0 = n_abort;
        @(posedge clk_i);
        cycle_start_i <= 1'b1;
        wait_sig(1, 1'b1, 20);
        flt[k] <= 1'b1;
        wait_sig(0, 1'b1, 20);
        cycle_start_i <= 1'b0;
        // The abort counter settles only after this edge, so look after the read
        rd_chk(off, exp_bit(k));
        chk(32'(n_abort != a0), 32'h1);
        if (k >= 3) begin
            chk({31'h0, start_blocked_o}, 32'h1);
            cycle_start_i <= 1'b1;
            repeat (10) @(posedge clk_i);
            chk({31'h0, cycle_active_o}, 32'h0);
            cycle_start_i <= 1'b0;
        end
        if (k == 8) chk({31'h0, drive_status_word_o[0]}, 32'h1);
        wr(`WCAM_OFF_CLEAR, 32'hFFFF_FFFF, 4'hF);
        rd_chk(off, exp_bit(k));
        @(posedge clk_i);
        flt[k] <= 1'b0;
        wr(`WCAM_OFF_CLEAR, 32'hFFFF_FFFF, ~s);
        rd_chk(off, exp_bit(k));
        wr(`WCAM_OFF_CLEAR, 32'hFFFF_FFFF, s);
        if (k == 8) begin
            wait_sig(2, 1'b1, 5);
            chk({31'h0, powerup_go_o}, 32'h1);
            chk({30'h0, powerup_action_o}, {30'h0, pu});
        end
        rd_chk(off, 32'h0);
        chk({31'h0, start_blocked_o}, 32'h0);
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        $display("Watchdog expired at %0t", $time);
        close_out();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h41e3d664));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) rd_chk(roff[i], rexp[i]);
        wr(8'h20, 32'hFFFF_FFFF, 4'hF);
        rd_chk(8'h20, 32'h0);
        wr(`WCAM_OFF_RFTIME, 32'h0000_0008, 4'hF);
        rd_chk(`WCAM_OFF_RFTIME, 32'h0000_0008);
        foreach (cases[i]) run_case(cases[i]);
        repeat (6) run_case(cases[$urandom_range(9)]);
        @(posedge clk_i);
        uls_d <= 8'h02;
        trig_d <= 8'h03;
        interlock_i <= 1'b1;
        part_present_i <= 1'b1;
        horn_number_i <= 8'h00;
        for (int k = 0; k < 8; k++) fault_case(k, 2'h0);
        for (int p = 0; p < 3; p++) fault_case(8, 2'(p));
        @(posedge clk_i);
        aux_24v_ok_i <= 1'b0;
        flt[8] <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd_chk(`WCAM_OFF_HW, 32'h0);
        flt[8] <= 1'b0;
        aux_24v_ok_i <= 1'b1;
        @(posedge clk_i);
        fieldbus_present_i <= 1'b0;
        flt[2] <= 1'b1;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rd_chk(`WCAM_OFF_COMM, 32'h0);
        run_case(cases[0]);
        close_out();
    end
endmodule // tb_top
